// ===== logic/net_indicator.sv
`timescale 1ns/100ps
// Operation
// (R01) alias is high switch digit then low switch digit, 0 to 255
// (R02) address is automatic; alias only offered when fixed address wanted
// (R03) power led green with power, red while shunt regulator dumps energy
// (R04) status led green with bridge enabled, red when inhibited or faulted
// (R05) link led on for valid idle link, flickers on traffic, else off
// (R06) network led steady green in operational
// (R07) network led blinks 200 ms on, 200 ms off in pre-operational
// (R08) network led single flash 200 ms then 1000 ms off in safe-op
// (R09) network led flickers 50/50 ms while booting, bootstrap, download
// (R10) network led off in init
// (R11) error led steady red after process data interface watchdog timeout
// (R12) error led blinks red on general configuration error
// (R13) error led flickers red when init reached with change flag 0x01
// (R14) error led single red flash on autonomous change with flag 0x01
// (R15) sync error makes the device leave its state for safe-operational; code does so only from operational
// (R16) error led double flashes after application watchdog timeout
// (R17) double flash followed by 1000 ms off before repeating
// (R18) error led shows highest priority error, off with none
// (R19) alias switches sampled on leaving reset, held until next reset
module net_indicator #(
  parameter int unsigned TICK_CYCLES = led_pkg::TICK_CYCLES,
  parameter int unsigned NUM_PORTS = led_pkg::NUM_LINK_PORTS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // alias switches and address mode
  input wire logic [3:0] alias_high_digit_switch,
  input wire logic [3:0] alias_low_digit_switch,
  input wire logic fixed_address_req,
  output logic [7:0] station_alias,
  output logic alias_in_use,
  // power stage
  input wire logic power_present,
  input wire logic shunt_active,
  input wire logic bridge_enabled,
  // slave state machine control
  input wire logic boot_done,
  input wire logic boot_error,
  input wire logic fw_download,
  input wire logic state_req_valid,
  input wire led_pkg::net_state_t state_request,
  input wire logic sync_error,
  input wire logic change_ack,
  output led_pkg::net_state_t net_state,
  output logic [7:0] change_field,
  // error sources
  input wire logic pdi_wd_timeout,
  input wire logic app_wd_timeout,
  input wire logic config_error,
  // link phy
  input wire logic [NUM_PORTS-1:0] link_valid,
  input wire logic [NUM_PORTS-1:0] link_activity,
  // indicator leds
  output logic power_led_green,
  output logic power_led_red,
  output logic status_led_green,
  output logic status_led_red,
  output logic net_led_green,
  output logic error_led_red,
  output logic [NUM_PORTS-1:0] link_led_green
);
  import led_pkg::*;

  net_state_t next_net_state;
  logic change_flag;
  logic alias_captured;
  logic blink_on;
  logic flicker_on;
  logic single_on;
  logic double_on;
  logic flicker_wrap;
  logic err_single;
  logic err_flicker;
  logic [NUM_PORTS-1:0] act_hold;

  // true for a state that the master may request
  function automatic logic is_target(input net_state_t s);
    case (s)
      ST_INIT, ST_PREOP, ST_BOOT, ST_SAFEOP, ST_OP: is_target = 1'b1;
      default: is_target = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // pattern timing
  // ****************************************************************
  led_pattern_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .blink_on(blink_on),
    .flicker_on(flicker_on),
    .single_on(single_on),
    .double_on(double_on),
    .flicker_wrap(flicker_wrap)
  );

  // ****************************************************************
  // station alias
  // ****************************************************************
  // capture switches once after reset release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      station_alias <= ALIAS_RESET;
      alias_captured <= 1'b0;
    end else if (!alias_captured) begin
      station_alias <= {alias_high_digit_switch,
                        alias_low_digit_switch};  // see (R01) see (R19)
      alias_captured <= 1'b1;
    end
  end

  // alias used only on request, else automatic position address
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      alias_in_use <= 1'b0;
    end else begin
      alias_in_use <= fixed_address_req && alias_captured;  // see (R02)
    end
  end

  // ****************************************************************
  // slave state machine
  // ****************************************************************
  // next state: boot errors drop to init, sync errors in op to safe-op
  always_comb begin
    next_net_state = net_state;
    case (net_state)
      ST_BOOTING: begin
        if (boot_error || boot_done) begin
          next_net_state = ST_INIT;
        end
      end
      ST_OP: begin
        if (boot_error) begin
          next_net_state = ST_INIT;
        end else if (sync_error) begin
          next_net_state = ST_SAFEOP;  // see (R15)
        end else if (state_req_valid && is_target(state_request)) begin
          next_net_state = state_request;
        end
      end
      default: begin
        if (boot_error) begin
          next_net_state = ST_INIT;
        end else if (state_req_valid && is_target(state_request)) begin
          next_net_state = state_request;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      net_state <= ST_BOOTING;
    end else begin
      net_state <= next_net_state;
    end
  end

  // change flag: set on autonomous change, cleared by ack, set wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      change_flag <= 1'b0;
    end else if (boot_error || (sync_error && net_state == ST_OP)) begin
      change_flag <= 1'b1;  // see (R15)
    end else if (change_ack) begin
      change_flag <= 1'b0;
    end
  end

  assign change_field = change_flag ? CHANGE_ERROR : CHANGE_NONE;

  // ****************************************************************
  // power and status leds
  // ****************************************************************
  // power led and bridge status led
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_led_green <= 1'b0;
      power_led_red <= 1'b0;
      status_led_green <= 1'b0;
      status_led_red <= 1'b0;
    end else begin
      power_led_green <= power_present && !shunt_active;  // see (R03)
      power_led_red <= power_present && shunt_active;  // see (R03)
      status_led_green <= bridge_enabled;  // see (R04)
      status_led_red <= !bridge_enabled;  // see (R04)
    end
  end

  // ****************************************************************
  // link leds
  // ****************************************************************
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_link
      // hold traffic until the current flicker period wraps
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          act_hold[p] <= 1'b0;
        end else if (link_activity[p]) begin
          act_hold[p] <= 1'b1;
        end else if (flicker_wrap) begin
          act_hold[p] <= 1'b0;
        end
      end

      // link led: off, steady, or flickering with traffic
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          link_led_green[p] <= 1'b0;
        end else begin
          link_led_green[p] <= link_valid[p] &&
            (!act_hold[p] || flicker_on);  // see (R05)
        end
      end
    end
  endgenerate

  // ****************************************************************
  // network status led
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      net_led_green <= 1'b0;
    end else if (fw_download) begin
      net_led_green <= flicker_on;  // see (R09)
    end else begin
      case (net_state)
        ST_OP: net_led_green <= 1'b1;  // see (R06)
        ST_PREOP: net_led_green <= blink_on;  // see (R07)
        ST_SAFEOP: net_led_green <= single_on;  // see (R08)
        ST_BOOTING, ST_BOOT: net_led_green <= flicker_on;  // see (R09)
        ST_INIT: net_led_green <= 1'b0;  // see (R10)
        default: net_led_green <= 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // error led
  // ****************************************************************
  assign err_flicker = change_flag && (net_state == ST_INIT);  // see (R13)
  assign err_single = change_flag && (net_state != ST_INIT);  // see (R14)

  // priority: solid, double, single, flicker, blink, off
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      error_led_red <= 1'b0;
    end else if (pdi_wd_timeout) begin
      error_led_red <= 1'b1;  // see (R11) see (R18)
    end else if (app_wd_timeout) begin
      error_led_red <= double_on;  // see (R16) see (R17)
    end else if (err_single) begin
      error_led_red <= single_on;  // see (R14)
    end else if (err_flicker) begin
      error_led_red <= flicker_on;  // see (R13)
    end else if (config_error) begin
      error_led_red <= blink_on;  // see (R12)
    end else begin
      error_led_red <= 1'b0;  // see (R18)
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_sync_in_op;
    sync_error && !boot_error && net_state == ST_OP;
  endsequence

  sequence s_forced_safeop;
    net_state == ST_SAFEOP && change_field == CHANGE_ERROR;
  endsequence

  property p_alias_value;
    $rose(alias_captured) |-> station_alias ==
      {$past(alias_high_digit_switch), $past(alias_low_digit_switch)};
  endproperty
  a_alias_value: assert property (p_alias_value)  // see (R01)
    else $error("alias not formed from switches");

  property p_alias_hold;
    alias_captured |=> $stable(station_alias) [*4];
  endproperty
  a_alias_hold: assert property (p_alias_hold)  // see (R19)
    else $error("alias changed after capture");

  property p_sync_safeop;
    s_sync_in_op |=> s_forced_safeop;
  endproperty
  a_sync_safeop: assert property (p_sync_safeop)  // see (R15)
    else $error("sync error did not force safe-operational");

  property p_power_red;
    power_present && shunt_active |=> power_led_red && !power_led_green;
  endproperty
  a_power_red: assert property (p_power_red)  // see (R03)
    else $error("power led not red while shunting");

  property p_status_red;
    !bridge_enabled |=> status_led_red && !status_led_green;
  endproperty
  a_status_red: assert property (p_status_red)  // see (R04)
    else $error("status led not red with bridge off");

  property p_op_steady;
    net_state == ST_OP && !fw_download |=> net_led_green;
  endproperty
  a_op_steady: assert property (p_op_steady)  // see (R06)
    else $error("network led not steady in operational");

  property p_init_off;
    net_state == ST_INIT && !fw_download |=> !net_led_green;
  endproperty
  a_init_off: assert property (p_init_off)  // see (R10)
    else $error("network led lit in init");

  property p_pdi_solid;
    pdi_wd_timeout |=> error_led_red;
  endproperty
  a_pdi_solid: assert property (p_pdi_solid)  // see (R11)
    else $error("error led not solid after pdi watchdog");

  property p_no_error_off;
    !pdi_wd_timeout && !app_wd_timeout && !change_flag && !config_error
      |=> !error_led_red;
  endproperty
  a_no_error_off: assert property (p_no_error_off)  // see (R18)
    else $error("error led lit with no error");

  property p_link_off;
    !link_valid[0] |=> !link_led_green[0];
  endproperty
  a_link_off: assert property (p_link_off)  // see (R05)
    else $error("link led lit on invalid link");

  property p_alias_use;
    alias_captured |=> alias_in_use == $past(fixed_address_req);
  endproperty
  a_alias_use: assert property (p_alias_use)  // see (R02)
    else $error("alias use does not follow fixed address request");

  property p_boot_err_init;
    boot_error |=> net_state == ST_INIT && change_field == CHANGE_ERROR;
  endproperty
  a_boot_err_init: assert property (p_boot_err_init)  // see (R13)
    else $error("boot error did not reach init with change flag");

  property p_app_double;
    app_wd_timeout && !pdi_wd_timeout |=> error_led_red == $past(double_on);
  endproperty
  a_app_double: assert property (p_app_double)  // see (R16)
    else $error("error led not double flashing after app watchdog");

endmodule

// ===== logic/led_pkg.sv
package led_pkg;

  // ****************************************************************
  // clock and tick timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // pattern times in milliseconds (one tick each)
  // ****************************************************************
  localparam int TIME_W = 11;
  localparam logic [TIME_W-1:0] BLINK_ON_MS = 11'h0c8;     // 200 ms
  localparam logic [TIME_W-1:0] BLINK_OFF_MS = 11'h0c8;    // 200 ms
  localparam logic [TIME_W-1:0] FLICKER_ON_MS = 11'h032;   // 50 ms
  localparam logic [TIME_W-1:0] FLICKER_OFF_MS = 11'h032;  // 50 ms
  localparam logic [TIME_W-1:0] FLASH_ON_MS = 11'h0c8;     // 200 ms
  localparam logic [TIME_W-1:0] FLASH_OFF_MS = 11'h3e8;    // 1000 ms
  localparam logic [TIME_W-1:0] DFLASH_GAP_MS = 11'h0c8;   // 200 ms
  localparam logic [TIME_W-1:0] DFLASH_OFF_MS = 11'h3e8;   // 1000 ms

  // ****************************************************************
  // alias, change field and ports
  // ****************************************************************
  localparam logic [7:0] ALIAS_RESET = 8'h00;
  localparam logic [7:0] CHANGE_NONE = 8'h00;
  localparam logic [7:0] CHANGE_ERROR = 8'h01;
  localparam int NUM_LINK_PORTS = 2;

  // slave state machine states, one-hot
  typedef enum logic [5:0] {
    ST_BOOTING = 6'h01,
    ST_INIT = 6'h02,
    ST_PREOP = 6'h04,
    ST_BOOT = 6'h08,
    ST_SAFEOP = 6'h10,
    ST_OP = 6'h20
  } net_state_t;

endpackage

// ===== logic/led_pattern_timer.sv
`timescale 1ns/100ps
module led_pattern_timer #(
  parameter int unsigned TICK_CYCLES = led_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // pattern waves, high while the led is lit, and the flicker period wrap pulse
  output logic blink_on,
  output logic flicker_on,
  output logic single_on,
  output logic double_on,
  output logic flicker_wrap
);
  import led_pkg::*;

  localparam int DIV_W = $clog2(TICK_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  // pattern periods: blink, flicker, single flash, double flash
  localparam logic [TIME_W-1:0] PERIOD [4] = '{
    TIME_W'(BLINK_ON_MS + BLINK_OFF_MS),
    TIME_W'(FLICKER_ON_MS + FLICKER_OFF_MS),
    TIME_W'(FLASH_ON_MS + FLASH_OFF_MS),
    TIME_W'(2 * FLASH_ON_MS + DFLASH_GAP_MS + DFLASH_OFF_MS)
  };

  logic [DIV_W-1:0] div_count;
  logic ms_tick;
  logic [TIME_W-1:0] ms_count [4];

  // ****************************************************************
  // millisecond tick
  // ****************************************************************
  assign ms_tick = (div_count == DIV_LAST);

  // tick divider
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_count <= '0;
    end else if (ms_tick) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  // ****************************************************************
  // pattern counters
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_pattern
      // free running millisecond counter per pattern
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          ms_count[i] <= '0;
        end else if (ms_tick) begin
          if (ms_count[i] == PERIOD[i] - 1'b1) begin
            ms_count[i] <= '0;
          end else begin
            ms_count[i] <= ms_count[i] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // registered waves
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      blink_on <= 1'b0;
      flicker_on <= 1'b0;
      single_on <= 1'b0;
      double_on <= 1'b0;
      flicker_wrap <= 1'b0;
    end else begin
      blink_on <= ms_count[0] < BLINK_ON_MS;
      flicker_on <= ms_count[1] < FLICKER_ON_MS;
      single_on <= ms_count[2] < FLASH_ON_MS;
      double_on <= (ms_count[3] < FLASH_ON_MS) ||
        ((ms_count[3] >= TIME_W'(FLASH_ON_MS + DFLASH_GAP_MS)) &&
         (ms_count[3] < TIME_W'(2 * FLASH_ON_MS + DFLASH_GAP_MS)));
      flicker_wrap <= ms_tick && (ms_count[1] == PERIOD[1] - 1'b1);
    end
  end

endmodule

// ===== verification/led_watcher.sv
`timescale 1ns/100ps
module led_watcher (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // watched led and statistics clear
  input wire logic led,
  input wire logic clear,
  // lengths of runs completed since clear, in clock cycles, and count of rising edges
  output logic [15:0] on_len,
  output logic [15:0] off_min,
  output logic [15:0] off_max,
  output logic [15:0] rises
);
  logic prev;
  logic seen;
  logic [15:0] run;

  // ****************************************************************
  // front-panel led model: times every lit and dark run
  // ****************************************************************
  // a run cut by clear is partial, so only runs begun after an edge count
  always_ff @(posedge sys_clk) begin
    if (!reset_n || clear) begin
      prev <= led;
      seen <= 1'b0;
      run <= 16'h0001;
      on_len <= 16'h0000;
      off_min <= 16'hffff;
      off_max <= 16'h0000;
      rises <= 16'h0000;
    end else if (led != prev) begin
      prev <= led;
      seen <= 1'b1;
      run <= 16'h0001;
      if (led) begin
        rises <= rises + 16'h0001;
      end
      if (seen && prev) begin
        on_len <= run;
      end
      if (seen && !prev) begin
        off_min <= (run < off_min) ? run : off_min;
        off_max <= (run > off_max) ? run : off_max;
      end
    end else begin
      run <= run + 16'h0001; // level held one more cycle
    end
  end
endmodule

// ===== verification/network_indicator_led_driver_tb_top.sv
`timescale 1ns/100ps
module network_indicator_led_driver_tb_top;
  import led_pkg::*;
  localparam int TK = 4;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] hi_sw = 4'ha;
  logic [3:0] lo_sw = 4'h5;
  logic fixed_req = 1'b1;
  logic pwr = 1'b0;
  logic shunt = 1'b0;
  logic bridge = 1'b0;
  logic boot_done = 1'b0;
  logic boot_err = 1'b0;
  logic fw_dl = 1'b0;
  logic req_v = 1'b0;
  net_state_t req_st = ST_INIT;
  logic sync_err = 1'b0;
  logic ack = 1'b0;
  logic pdi_wd = 1'b0;
  logic app_wd = 1'b0;
  logic cfg_err = 1'b0;
  logic [1:0] lnk_v = 2'h0;
  logic [1:0] lnk_a = 2'h0;
  logic [7:0] alias_v;
  logic alias_use;
  net_state_t state;
  logic [7:0] chg;
  logic pg, pr, sg, sr, net_led, err_led;
  logic [1:0] lnk_led;
  logic clr = 1'b0;
  logic [2:0] watched;
  logic [15:0] on_len [3];
  logic [15:0] off_min [3];
  logic [15:0] off_max [3];
  logic [15:0] rises [3];
  int bad_count = 0;
  int checks = 0;

  // ****************************************************************
  // clock, design and led models
  // ****************************************************************
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  net_indicator #(.TICK_CYCLES(TK), .NUM_PORTS(2)) net_indicator_i (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .alias_high_digit_switch(hi_sw), .alias_low_digit_switch(lo_sw),
    .fixed_address_req(fixed_req), .station_alias(alias_v),
    .alias_in_use(alias_use), .power_present(pwr), .shunt_active(shunt),
    .bridge_enabled(bridge), .boot_done(boot_done), .boot_error(boot_err),
    .fw_download(fw_dl), .state_req_valid(req_v), .state_request(req_st),
    .sync_error(sync_err), .change_ack(ack), .net_state(state),
    .change_field(chg), .pdi_wd_timeout(pdi_wd), .app_wd_timeout(app_wd),
    .config_error(cfg_err), .link_valid(lnk_v), .link_activity(lnk_a),
    .power_led_green(pg), .power_led_red(pr), .status_led_green(sg),
    .status_led_red(sr), .net_led_green(net_led), .error_led_red(err_led),
    .link_led_green(lnk_led));

  assign watched = {lnk_led[0], err_led, net_led};
  for (genvar g = 0; g < 3; g++) begin : gen_watch
    led_watcher led_watcher_i (
      .sys_clk(sys_clk), .reset_n(reset_n), .led(watched[g]),
      .clear(clr), .on_len(on_len[g]), .off_min(off_min[g]),
      .off_max(off_max[g]), .rises(rises[g]));
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic end_of_test();
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] cyc(logic [TIME_W-1:0] ms);
    return 16'(ms) * 16'(TK);
  endfunction

  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // watch one led for a span, then compare its lit and dark runs
  task automatic pattern(int w, int span, logic [15:0] on_c,
                         logic [15:0] omin, logic [15:0] omax);
    step(3); // let a newly selected pattern reach the led first
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(span);
    check("on run", on_len[w], on_c);
    check("shortest off run", off_min[w], omin);
    check("longest off run", off_max[w], omax);
  endtask

  // watch one led for a span and expect it to hold a level
  task automatic steady(int w, int span, logic lvl);
    step(3); // let a newly selected level reach the led first
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(span);
    check("rising edges", rises[w], 16'h0000);
    check("led level", {15'h0000, watched[w]}, {15'h0000, lvl});
  endtask

  task automatic request(net_state_t st);
    req_st = st;
    req_v = 1'b1;
    step(1);
    req_v = 1'b0;
    step(3);
    check("net state", {10'h000, state}, {10'h000, st});
  endtask

  task automatic power_case(logic p, logic s, logic b, logic [3:0] exp);
    pwr = p;
    shunt = s;
    bridge = b;
    step(3);
    check("power and status leds", {12'h000, pg, pr, sg, sr}, {12'h000, exp});
  endtask

  // ****************************************************************
  // watchdog and main sequence
  // ****************************************************************
  initial begin
    repeat (90000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    step(16);
    reset_n = 1'b1;
    step(1);
    hi_sw = 4'h3;
    lo_sw = 4'hc;
    step(3);
    check("station alias", {8'h00, alias_v}, 16'h00a5);
    check("alias in use", {15'h0000, alias_use}, 16'h0001);
    fixed_req = 1'b0;
    step(3);
    check("alias in use", {15'h0000, alias_use}, 16'h0000);
    pattern(0, 1000, cyc(FLICKER_ON_MS), cyc(FLICKER_OFF_MS),
            cyc(FLICKER_OFF_MS));
    steady(1, 100, 1'b0);
    power_case(1'b1, 1'b0, 1'b1, 4'b1010);
    power_case(1'b1, 1'b1, 1'b0, 4'b0101);
    power_case(1'b0, 1'b0, 1'b0, 4'b0001);
    lnk_v = 2'b01;
    steady(2, 100, 1'b1);
    check("second link led", {14'h0000, lnk_led}, 16'h0001);
    lnk_a = 2'b01;
    pattern(2, 1000, cyc(FLICKER_ON_MS), cyc(FLICKER_OFF_MS),
            cyc(FLICKER_OFF_MS));
    lnk_a = 2'b00;
    lnk_v = 2'b00;
    step(300);
    steady(2, 100, 1'b0);
    boot_done = 1'b1;
    step(1);
    boot_done = 1'b0;
    step(3);
    check("net state", {10'h000, state}, {10'h000, ST_INIT});
    steady(0, 500, 1'b0);
    request(ST_BOOT);
    pattern(0, 1000, cyc(FLICKER_ON_MS), cyc(FLICKER_OFF_MS),
            cyc(FLICKER_OFF_MS));
    request(ST_PREOP);
    pattern(0, 4000, cyc(BLINK_ON_MS), cyc(BLINK_OFF_MS),
            cyc(BLINK_OFF_MS));
    request(ST_SAFEOP);
    pattern(0, 10000, cyc(FLASH_ON_MS), cyc(FLASH_OFF_MS),
            cyc(FLASH_OFF_MS));
    request(ST_OP);
    steady(0, 500, 1'b1);
    fw_dl = 1'b1;
    pattern(0, 1000, cyc(FLICKER_ON_MS), cyc(FLICKER_OFF_MS),
            cyc(FLICKER_OFF_MS));
    fw_dl = 1'b0;
    sync_err = 1'b1;
    step(1);
    sync_err = 1'b0;
    step(3);
    check("net state", {10'h000, state}, {10'h000, ST_SAFEOP});
    check("change field", {8'h00, chg}, {8'h00, CHANGE_ERROR});
    pattern(1, 10000, cyc(FLASH_ON_MS), cyc(FLASH_OFF_MS),
            cyc(FLASH_OFF_MS));
    ack = 1'b1;
    step(1);
    ack = 1'b0;
    step(3);
    check("change field", {8'h00, chg}, {8'h00, CHANGE_NONE});
    steady(1, 300, 1'b0);
    boot_err = 1'b1;
    step(1);
    boot_err = 1'b0;
    step(3);
    check("net state", {10'h000, state}, {10'h000, ST_INIT});
    pattern(1, 1000, cyc(FLICKER_ON_MS), cyc(FLICKER_OFF_MS),
            cyc(FLICKER_OFF_MS));
    ack = 1'b1;
    step(1);
    ack = 1'b0;
    cfg_err = 1'b1;
    pattern(1, 4000, cyc(BLINK_ON_MS), cyc(BLINK_OFF_MS),
            cyc(BLINK_OFF_MS));
    app_wd = 1'b1;
    pattern(1, 12000, cyc(FLASH_ON_MS), cyc(DFLASH_GAP_MS),
            cyc(DFLASH_OFF_MS));
    pdi_wd = 1'b1;
    steady(1, 500, 1'b1);
    pdi_wd = 1'b0;
    app_wd = 1'b0;
    cfg_err = 1'b0;
    step(3);
    steady(1, 300, 1'b0);
    // a second reset recaptures the switches as they stand now
    reset_n = 1'b0;
    step(2);
    reset_n = 1'b1;
    step(3);
    check("station alias", {8'h00, alias_v}, 16'h003c);
    check("net state", {10'h000, state}, {10'h000, ST_BOOTING});
    end_of_test();
  end
endmodule
